//--- inc/depct_pkg.sv
// shared constants and types for the debug exit and pc tracking block
package depct_pkg;

    // ========================================================
    // widths
    localparam int WORD_W = 32;
    localparam int MODE_W = 5;

    // ========================================================
    // program counter steps, in word addresses
    localparam logic [31:0] WORD_BYTES      = 32'h0000_0004;
    localparam logic [31:0] BP_ENTRY_WORDS  = 32'h0000_0004;
    localparam logic [31:0] EXC_ENTRY_WORDS = 32'h0000_0003;
    localparam logic [31:0] INSTR_WORDS     = 32'h0000_0001;
    localparam logic [31:0] SYS_WORDS       = 32'h0000_0003;

    // the same steps in bytes
    localparam logic [31:0] BP_ENTRY_BYTES  = BP_ENTRY_WORDS * WORD_BYTES;
    localparam logic [31:0] EXC_ENTRY_BYTES = EXC_ENTRY_WORDS * WORD_BYTES;
    localparam logic [31:0] INSTR_BYTES     = INSTR_WORDS * WORD_BYTES;
    localparam logic [31:0] SYS_BYTES       = SYS_WORDS * WORD_BYTES;

    // ========================================================
    // reset values
    localparam logic [31:0]     PC_RESET   = 32'h0000_0000;
    localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;

    // ========================================================
    // debug sequencer states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,  // normal execution, memory qualifier
        ST_HOLD  = 3'b001,  // watchpoint with abort, entry held off
        ST_DEBUG = 3'b010,  // halted, debug qualifier
        ST_SYS   = 3'b011   // system-speed access out of debug
    } depct_state_type;

endpackage : depct_pkg

//--- design/depct_pc_track.sv
// program counter tracking register with load and add
`timescale 1ns/10ps
module depct_pc_track (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    input  wire logic        add_en,
    input  wire logic [31:0] add_value,
    output logic      [31:0] pc
);

    // ========================================================
    // pc register: load wins over add
    always_ff @(posedge clk) begin
        if (reset) begin
            pc <= depct_pkg::PC_RESET;
        end else if (load) begin
            pc <= load_value;
        end else if (add_en) begin
            pc <= pc + add_value;
        end
    end

endmodule : depct_pc_track

//--- design/depct_core.sv
// debug entry and exit sequencer with program counter tracking
// Behaviour
// - resumption waits until test port enters Run-Test/Idle
// - all cores resume together on shared Run-Test/Idle entry
// - debug acknowledge high while in debug state
// - pipeline flushed on entry, refetched on exit
// - last memory access in same cycle acknowledge rises
// - first new memory access in cycle after acknowledge falls
// - acknowledge may fall during system-speed access
// - control input forces acknowledge high across system-speed access
// - breakpoint entry advances pc by sixteen bytes
// - each debug instruction advances pc by four bytes
// - watchpoint entry steps pc like breakpoint
// - watchpoint with data abort held off until abort vector fetched
// - exception with watchpoint enters debug in exception mode
// - entry with exception advances pc by three words
// - debug request entry advances pc by three words
// - re-executed aborted watchpoint instruction re-enters debug
// - core clock qualified by memory or debug qualifier by state
// - return from system-speed access sets break bit high
`timescale 1ns/10ps
module depct_core (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        memory_clock_qualifier,
    input  wire logic        debug_clock_qualifier,
    input  wire logic        force_ack,
    input  wire logic        bp_hit,
    input  wire logic        wp_hit,
    input  wire logic        dbg_request,
    input  wire logic        exception_pending,
    input  wire logic        data_abort,
    input  wire logic        abort_vector_fetched,
    input  wire logic [4:0]  exc_mode_in,
    input  wire logic [31:0] core_pc,
    input  wire logic        instr_load,
    input  wire logic        break_bit_in,
    input  wire logic        instr_is_branch,
    input  wire logic [31:0] branch_target,
    input  wire logic        mem_access_done,
    input  wire logic        tap_run_idle,
    input  wire logic        tap_resume_instr,
    output logic             debug_ack_out,
    output logic             core_debug_qual,
    output logic             mem_access_en,
    output logic             pipe_flush,
    output logic             pipe_refetch,
    output logic             resume_pulse,
    output logic             break_scan_bit,
    output logic             entry_with_exc,
    output logic      [4:0]  entry_mode,
    output logic      [31:0] pc_out
);

    depct_pkg::depct_state_type state;
    depct_pkg::depct_state_type next_state;
    logic        run_idle_prev;
    logic        resume_evt;
    logic        instr_exec;
    logic        pending_brk;
    logic        arm_exit;
    logic        arm_sys;
    logic        enter_debug;
    logic        entry_exc;
    logic        pc_load;
    logic [31:0] pc_load_value;
    logic        pc_add;
    logic [31:0] pc_add_value;

    // ========================================================
    // event decode
    // resume: rising entry to idle with resume instruction current
    assign resume_evt = tap_run_idle & ~run_idle_prev
                        & tap_resume_instr;
    assign instr_exec = instr_load & debug_clock_qualifier
                        & (state == depct_pkg::ST_DEBUG);
    assign enter_debug = (next_state == depct_pkg::ST_DEBUG)
                         & ((state == depct_pkg::ST_RUN)
                         | (state == depct_pkg::ST_HOLD));
    // entry that carries an exception or request steps by three
    assign entry_exc = (state == depct_pkg::ST_HOLD)
                       | (~bp_hit & wp_hit & exception_pending)
                       | (~bp_hit & ~wp_hit & dbg_request);

    // idle edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            run_idle_prev <= 1'b0;
        end else begin
            run_idle_prev <= tap_run_idle;
        end
    end

    // ========================================================
    // next state
    always_comb begin
        next_state = state;
        case (state)
            depct_pkg::ST_RUN: begin
                if (memory_clock_qualifier) begin
                    if (~bp_hit & wp_hit & data_abort) begin
                        next_state = depct_pkg::ST_HOLD;
                    end else if (bp_hit | wp_hit | dbg_request) begin
                        next_state = depct_pkg::ST_DEBUG;
                    end
                end
            end
            depct_pkg::ST_HOLD: begin
                if (memory_clock_qualifier & abort_vector_fetched) begin
                    next_state = depct_pkg::ST_DEBUG;
                end
            end
            depct_pkg::ST_DEBUG: begin
                // nothing leaves debug before the idle entry
                if (resume_evt & arm_exit) begin
                    next_state = depct_pkg::ST_RUN;
                end else if (resume_evt & arm_sys) begin
                    next_state = depct_pkg::ST_SYS;
                end
            end
            depct_pkg::ST_SYS: begin
                if (memory_clock_qualifier & mem_access_done) begin
                    next_state = depct_pkg::ST_DEBUG;
                end
            end
            default: begin
                next_state = depct_pkg::ST_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= depct_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ========================================================
    // break-bit tracking of scanned instructions
    always_ff @(posedge clk) begin
        if (reset) begin
            pending_brk <= 1'b0;
            arm_exit    <= 1'b0;
            arm_sys     <= 1'b0;
        end else if (state != depct_pkg::ST_DEBUG
                     || next_state != depct_pkg::ST_DEBUG) begin
            pending_brk <= 1'b0;
            arm_exit    <= 1'b0;
            arm_sys     <= 1'b0;
        end else if (instr_exec) begin
            // high bit before a low-bit branch arms exit
            pending_brk <= break_bit_in;
            arm_exit    <= pending_brk & ~break_bit_in
                           & instr_is_branch;
            arm_sys     <= pending_brk & ~break_bit_in
                           & ~instr_is_branch;
        end
    end

    // ========================================================
    // acknowledge, qualifier select and memory access gate
    always_ff @(posedge clk) begin
        if (reset) begin
            debug_ack_out   <= 1'b0;
            core_debug_qual <= 1'b0;
            mem_access_en   <= 1'b1;
        end else begin
            // drops during system access unless forced
            debug_ack_out   <= (next_state == depct_pkg::ST_DEBUG)
                               | (force_ack
                               & (next_state == depct_pkg::ST_SYS));
            core_debug_qual <= (next_state == depct_pkg::ST_DEBUG);
            // lags the state by one cycle
            mem_access_en   <= (state != depct_pkg::ST_DEBUG);
        end
    end

    // ========================================================
    // pipeline flush, refetch and resume pulses
    always_ff @(posedge clk) begin
        if (reset) begin
            pipe_flush   <= 1'b0;
            pipe_refetch <= 1'b0;
            resume_pulse <= 1'b0;
        end else begin
            pipe_flush   <= enter_debug;
            pipe_refetch <= (state == depct_pkg::ST_DEBUG)
                            & (next_state == depct_pkg::ST_RUN);
            resume_pulse <= resume_evt & (arm_exit | arm_sys);
        end
    end

    // ========================================================
    // entry cause: break bit, mode and exception flag
    always_ff @(posedge clk) begin
        if (reset) begin
            break_scan_bit <= 1'b0;
            entry_with_exc <= 1'b0;
            entry_mode     <= depct_pkg::MODE_RESET;
        end else if (enter_debug) begin
            break_scan_bit <= ~bp_hit | (state == depct_pkg::ST_HOLD);
            entry_with_exc <= entry_exc;
            if (entry_exc & ~(dbg_request & ~wp_hit & ~bp_hit)) begin
                entry_mode <= exc_mode_in;
            end
        end else if (state == depct_pkg::ST_SYS
                     && next_state == depct_pkg::ST_DEBUG) begin
            break_scan_bit <= 1'b1;
        end
    end

    // ========================================================
    // pc update selection
    always_comb begin
        pc_load       = 1'b0;
        pc_load_value = core_pc;
        pc_add        = 1'b0;
        pc_add_value  = depct_pkg::INSTR_BYTES;
        case (state)
            depct_pkg::ST_RUN, depct_pkg::ST_HOLD: begin
                pc_load = 1'b1;
                if (enter_debug & entry_exc) begin
                    pc_load_value = core_pc
                                    + depct_pkg::EXC_ENTRY_BYTES;
                end else if (enter_debug) begin
                    pc_load_value = core_pc
                                    + depct_pkg::BP_ENTRY_BYTES;
                end
            end
            depct_pkg::ST_DEBUG: begin
                if (next_state == depct_pkg::ST_RUN) begin
                    pc_load       = 1'b1;
                    pc_load_value = branch_target;
                end else if (instr_exec) begin
                    pc_add = 1'b1;
                end
            end
            depct_pkg::ST_SYS: begin
                if (next_state == depct_pkg::ST_DEBUG) begin
                    pc_add       = 1'b1;
                    pc_add_value = depct_pkg::SYS_BYTES;
                end
            end
            default: begin
                pc_load = 1'b0;
            end
        endcase
    end

    // pc register
    depct_pc_track u_pc (
        .clk        (clk),
        .reset      (reset),
        .load       (pc_load),
        .load_value (pc_load_value),
        .add_en     (pc_add),
        .add_value  (pc_add_value),
        .pc         (pc_out)
    );

    // ========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_ack_in_debug: assert property (
        state == depct_pkg::ST_DEBUG |-> debug_ack_out && core_debug_qual)
        else $error("ack or qualifier low in debug");
    a_bp_entry_pc: assert property (
        state == depct_pkg::ST_RUN && memory_clock_qualifier && bp_hit
        |=> pc_out == $past(core_pc) + 32'h0000_0010
            && state == depct_pkg::ST_DEBUG)
        else $error("breakpoint entry pc wrong");
    a_instr_pc_step: assert property (
        instr_exec && next_state == depct_pkg::ST_DEBUG
        |=> pc_out == $past(pc_out) + 32'h0000_0004)
        else $error("debug instruction pc step wrong");
    a_req_entry_pc: assert property (
        state == depct_pkg::ST_RUN && memory_clock_qualifier
        && dbg_request && !bp_hit && !wp_hit
        |=> pc_out == $past(core_pc) + 32'h0000_000C)
        else $error("request entry pc wrong");
    a_exc_entry_pc: assert property (
        state == depct_pkg::ST_RUN && memory_clock_qualifier && wp_hit
        && exception_pending && !bp_hit && !data_abort
        |=> pc_out == $past(core_pc) + 32'h0000_000C
            && entry_mode == $past(exc_mode_in))
        else $error("exception entry pc or mode wrong");
    a_abort_hold: assert property (
        state == depct_pkg::ST_RUN && memory_clock_qualifier && wp_hit
        && data_abort && !bp_hit
        |=> state == depct_pkg::ST_HOLD && !debug_ack_out)
        else $error("abort entry not held off");
    a_resume_wait: assert property (
        state == depct_pkg::ST_DEBUG && !resume_evt
        |=> state == depct_pkg::ST_DEBUG)
        else $error("left debug without idle entry");
    a_resume_once: assert property (
        resume_pulse |=> !resume_pulse)
        else $error("resume took effect twice");
    a_mem_stop: assert property (
        $rose(debug_ack_out) && state == depct_pkg::ST_DEBUG
        |-> mem_access_en ##1 !mem_access_en)
        else $error("memory access not stopped after ack rise");
    a_mem_restart: assert property (
        $fell(debug_ack_out) && state == depct_pkg::ST_RUN
        |-> !mem_access_en ##1 mem_access_en)
        else $error("memory access not restarted after ack fall");
    a_force_ack: assert property (
        state == depct_pkg::ST_SYS && $past(force_ack) |-> debug_ack_out)
        else $error("forced ack low in system access");
    a_sys_return: assert property (
        state == depct_pkg::ST_SYS && memory_clock_qualifier
        && mem_access_done
        |=> state == depct_pkg::ST_DEBUG && break_scan_bit
            && pc_out == $past(pc_out) + 32'h0000_000C)
        else $error("system access return wrong");

    c_bp_exit: cover property (
        pipe_flush ##[1:200] pipe_refetch);
    c_sys_access: cover property (
        state == depct_pkg::ST_SYS ##[1:50] state == depct_pkg::ST_DEBUG);
    c_abort_entry: cover property (
        state == depct_pkg::ST_HOLD ##[1:50] state == depct_pkg::ST_DEBUG);

endmodule : depct_core

//--- tb/depct_debugger_model.sv
// external debugger model: scan chain loading and test port sequencing
`timescale 1ns/10ps
module depct_debugger_model (
    input  wire logic        clk,
    output logic             debug_clock_qualifier,
    output logic             instr_load,
    output logic             break_bit_in,
    output logic             instr_is_branch,
    output logic      [31:0] branch_target,
    output logic             tap_run_idle,
    output logic             tap_resume_instr
);
    logic [32:0] chain;

    // ========================================================
    // idle levels at time zero
    initial begin
        debug_clock_qualifier = 1'h0;
        instr_load            = 1'h0;
        break_bit_in          = 1'h0;
        instr_is_branch       = 1'h0;
        branch_target         = 32'h0000_0000;
        tap_run_idle          = 1'h0;
        tap_resume_instr      = 1'h0;
        chain                 = 33'h0_0000_0000;
    end

    // ========================================================
    // shift one value in, break bit leading, then clock it into the core
    task automatic scan(input logic brk, input logic [31:0] word,
                        input logic [31:0] target, input logic qual);
        logic [32:0] value;
        value = {brk, word};
        @(posedge clk);
        tap_run_idle     <= 1'h0;  // leaves idle to shift data
        tap_resume_instr <= 1'h0;
        for (int i = 32; i >= 0; i--) begin
            @(posedge clk);
            chain <= {chain[31:0], value[i]};
        end
        @(posedge clk);
        instr_load            <= 1'h1;
        debug_clock_qualifier <= qual;
        break_bit_in          <= chain[32];
        instr_is_branch       <= (chain[27:25] == 3'h5);
        branch_target         <= target;
        @(posedge clk);
        instr_load            <= 1'h0;
        debug_clock_qualifier <= 1'h0;
        break_bit_in          <= ~chain[32];  // driven to the inverse of the scanned break bit
        instr_is_branch       <= ~(chain[27:25] == 3'h5);
    endtask : scan

    // ========================================================
    // select resume, then enter run-test/idle once
    task automatic restart();
        @(posedge clk);
        tap_run_idle     <= 1'h0;
        tap_resume_instr <= 1'h1;
        @(posedge clk);
        tap_run_idle     <= 1'h1;
        @(posedge clk);
    endtask : restart
endmodule : depct_debugger_model

//--- tb/depct_core_test.sv
// self-checking bench for the debug exit and pc tracking sequencer
`timescale 1ns/10ps
module depct_core_test;
    localparam logic [31:0] NOP_WORD = 32'hE1A0_0000;
    localparam logic [31:0] BR_WORD  = 32'hEAFF_FFF9;
    localparam logic [31:0] LD_WORD  = 32'hE590_0000;

    logic        clk, reset, memory_clock_qualifier, force_ack;
    logic        bp_hit, wp_hit, dbg_request, exception_pending, data_abort;
    logic        abort_vector_fetched, mem_access_done;
    logic [4:0]  exc_mode_in;
    logic [31:0] core_pc;
    logic        debug_clock_qualifier, instr_load, break_bit_in;
    logic        instr_is_branch, tap_run_idle, tap_resume_instr;
    logic [31:0] branch_target;
    logic        debug_ack_out, core_debug_qual, mem_access_en, pipe_flush;
    logic        pipe_refetch, resume_pulse, break_scan_bit, entry_with_exc;
    logic [4:0]  entry_mode;
    logic [31:0] pc_out;
    int          n_errors, check_count;

    // ========================================================
    // clock, design and debugger
    always #25 clk = ~clk;

    depct_core u_depct_core (
        .clk(clk), .reset(reset),
        .memory_clock_qualifier(memory_clock_qualifier),
        .debug_clock_qualifier(debug_clock_qualifier),
        .force_ack(force_ack), .bp_hit(bp_hit), .wp_hit(wp_hit),
        .dbg_request(dbg_request), .exception_pending(exception_pending),
        .data_abort(data_abort), .abort_vector_fetched(abort_vector_fetched),
        .exc_mode_in(exc_mode_in), .core_pc(core_pc),
        .instr_load(instr_load), .break_bit_in(break_bit_in),
        .instr_is_branch(instr_is_branch), .branch_target(branch_target),
        .mem_access_done(mem_access_done), .tap_run_idle(tap_run_idle),
        .tap_resume_instr(tap_resume_instr), .debug_ack_out(debug_ack_out),
        .core_debug_qual(core_debug_qual), .mem_access_en(mem_access_en),
        .pipe_flush(pipe_flush), .pipe_refetch(pipe_refetch),
        .resume_pulse(resume_pulse), .break_scan_bit(break_scan_bit),
        .entry_with_exc(entry_with_exc), .entry_mode(entry_mode),
        .pc_out(pc_out)
    );

    depct_debugger_model u_depct_debugger_model (
        .clk(clk), .debug_clock_qualifier(debug_clock_qualifier),
        .instr_load(instr_load), .break_bit_in(break_bit_in),
        .instr_is_branch(instr_is_branch), .branch_target(branch_target),
        .tap_run_idle(tap_run_idle), .tap_resume_instr(tap_resume_instr)
    );

    // ========================================================
    // shared helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // hits is bp, wp, request, exception, abort
    task automatic pulse_entry(input logic [4:0] hits, input logic [31:0] p);
        @(posedge clk);
        {bp_hit, wp_hit, dbg_request, exception_pending, data_abort} <= hits;
        core_pc <= p;
        @(posedge clk);
        {bp_hit, wp_hit, dbg_request, exception_pending, data_abort} <= 5'h00;
        #1;
    endtask : pulse_entry

    // two fillers, the last with the high bit, then return branch, resume
    task automatic leave(input logic [31:0] target, input logic [31:0] exp);
        u_depct_debugger_model.scan(1'h0, NOP_WORD, target, 1'h1);
        u_depct_debugger_model.scan(1'h1, NOP_WORD, target, 1'h1);
        u_depct_debugger_model.scan(1'h0, BR_WORD, target, 1'h1);
        @(posedge clk);
        #1;
        chk(pc_out, exp);
        chk(debug_ack_out, 1'h1);
        u_depct_debugger_model.restart();
        #1;
        chk(debug_ack_out, 1'h0);
        chk(core_debug_qual, 1'h0);
        chk(pc_out, target);
        chk(pipe_refetch, 1'h1);
        chk(resume_pulse, 1'h1);
        @(posedge clk);
        #1;
        chk(mem_access_en, 1'h1);
        chk(resume_pulse, 1'h0);
        chk(pipe_refetch, 1'h0);
    endtask : leave

    // one system-speed access out of debug
    task automatic sys_access(input logic frc, input logic [31:0] base);
        logic done;
        done = 1'h0;
        force_ack <= frc;
        u_depct_debugger_model.scan(1'h1, LD_WORD, 32'h0000_0000, 1'h1);
        u_depct_debugger_model.scan(1'h0, NOP_WORD, 32'h0000_0000, 1'h1);
        u_depct_debugger_model.restart();
        #1;
        chk(debug_ack_out, frc);
        chk(core_debug_qual, 1'h0);
        repeat (2) @(posedge clk);
        #1;
        chk(mem_access_en, 1'h1);
        @(posedge clk);
        mem_access_done <= 1'h1;
        for (int i = 0; i < 8 && !done; i++) begin
            @(posedge clk);
            mem_access_done <= 1'h0;
            #1;
            done = (core_debug_qual === 1'h1);
        end
        if (!done) begin
            n_errors++;
            $display("[FAIL] %0t no return from system access", $time);
            results();
        end
        chk(debug_ack_out, 1'h1);
        chk(break_scan_bit, 1'h1);
        chk(pc_out, base + 32'h0000_0014);
    endtask : sys_access

    // ========================================================
    // scenarios
    task automatic t_reset();
        chk(debug_ack_out, 1'h0);
        chk(mem_access_en, 1'h1);
        chk({pipe_flush, resume_pulse, break_scan_bit}, 3'h0);
        chk(entry_mode, 5'h00);
        chk(pc_out, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_breakpoint();
        pulse_entry(5'h10, 32'h0000_1000);
        chk(debug_ack_out, 1'h1);
        chk(core_debug_qual, 1'h1);
        chk(pc_out, 32'h0000_1010);
        chk(pipe_flush, 1'h1);
        chk(break_scan_bit, 1'h0);
        @(posedge clk);
        #1;
        chk(mem_access_en, 1'h0);
        chk(pipe_flush, 1'h0);
        u_depct_debugger_model.restart();
        #1;
        chk(debug_ack_out, 1'h1);
        chk(resume_pulse, 1'h0);
        u_depct_debugger_model.scan(1'h0, NOP_WORD, 32'h0000_0000, 1'h0);
        @(posedge clk);
        #1;
        chk(pc_out, 32'h0000_1010);
        u_depct_debugger_model.scan(1'h0, NOP_WORD, 32'h0000_0000, 1'h1);
        @(posedge clk);
        #1;
        chk(pc_out, 32'h0000_1014);
        leave(32'h0000_1000, 32'h0000_1020);
        $display("test breakpoint done");
    endtask : t_breakpoint

    task automatic t_request();
        memory_clock_qualifier <= 1'h0;
        pulse_entry(5'h04, 32'h0000_2000);
        chk(debug_ack_out, 1'h0);
        memory_clock_qualifier <= 1'h1;
        pulse_entry(5'h04, 32'h0000_2000);
        chk(pc_out, 32'h0000_200C);
        chk({entry_with_exc, break_scan_bit}, 2'h3);
        sys_access(1'h0, 32'h0000_200C);
        sys_access(1'h1, 32'h0000_2020);
        leave(32'h0000_2000, 32'h0000_2040);
        force_ack <= 1'h0;
        $display("test request done");
    endtask : t_request

    task automatic t_watch();
        exc_mode_in <= 5'h12;
        pulse_entry(5'h08, 32'h0000_3000);
        chk(pc_out, 32'h0000_3010);
        chk(break_scan_bit, 1'h1);
        leave(32'h0000_3004, 32'h0000_301C);
        pulse_entry(5'h0A, 32'h0000_3100);
        chk(pc_out, 32'h0000_310C);
        chk({entry_with_exc, entry_mode}, 6'h32);
        leave(32'h0000_3100, 32'h0000_3118);
        $display("test watchpoint done");
    endtask : t_watch

    task automatic t_hold();
        exc_mode_in <= 5'h17;
        pulse_entry(5'h09, 32'h0000_4000);
        chk(debug_ack_out, 1'h0);
        @(posedge clk);
        abort_vector_fetched <= 1'h1;
        core_pc <= 32'h0000_0010;
        @(posedge clk);
        abort_vector_fetched <= 1'h0;
        #1;
        chk(debug_ack_out, 1'h1);
        chk(pc_out, 32'h0000_001C);
        chk(entry_mode, 5'h17);
        chk(break_scan_bit, 1'h1);
        leave(32'h0000_0010, 32'h0000_0028);
        // refetched watchpointed instruction traps again
        pulse_entry(5'h08, 32'h0000_4000);
        chk(debug_ack_out, 1'h1);
        chk(pc_out, 32'h0000_4010);
        leave(32'h0000_4004, 32'h0000_401C);
        $display("test hold done");
    endtask : t_hold

    // ========================================================
    // main sequence
    initial begin
        clk = 1'h0;
        reset = 1'h1;
        memory_clock_qualifier = 1'h1;
        {force_ack, bp_hit, wp_hit, dbg_request} = 4'h0;
        {exception_pending, data_abort, abort_vector_fetched} = 3'h0;
        mem_access_done = 1'h0;
        exc_mode_in = 5'h00;
        core_pc = 32'h0000_0000;
        n_errors = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        #1;
        t_reset();
        t_breakpoint();
        t_request();
        t_watch();
        t_hold();
        results();
    end
endmodule : depct_core_test
